// ===== src/isr_regs.svh
// Register offsets, field positions, reset values and counts
`ifndef ISR_REGS_SVH
`define ISR_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (plain register port, 16-bit data)
// ----------------------------------------------------------------
`define ISR_REG_PTR0        4'h0
`define ISR_REG_PTR1        4'h1
`define ISR_REG_POWER_CTRL  4'h2
`define ISR_REG_STATUS      4'h3
`define ISR_REG_LAST_ADDR   4'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISR_RI_BIT          0
`define ISR_CARRY_BIT       0
`define ISR_ZERO_BIT        1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ISR_PTR_RST         16'h0000
`define ISR_RI_RST          1'b1
`define ISR_STATUS_RST      2'h0

// ----------------------------------------------------------------
// Alias addresses and timing counts
// ----------------------------------------------------------------
`define ISR_ALIAS0_ADDR     16'h0000
`define ISR_ALIAS1_ADDR     16'h0001
`define ISR_RST_PULSE_CYC   4'h8

`endif

// ===== src/isr_pkg.sv
// Types shared by the indirect store and software reset block
package isr_pkg;

  typedef enum logic [1:0] {
    op_no_operation,
    op_store_w_indirect,
    op_sw_reset
  } isr_op_e;

  typedef enum logic [1:0] {
    mode_pre_inc,
    mode_pre_dec,
    mode_post_inc,
    mode_post_dec
  } isr_mode_e;

  typedef logic [15:0] isr_ptr_t;

endpackage : isr_pkg

// ===== src/isr_ptr_calc.sv
// Effective address and next pointer value for one pointer
`timescale 1ns/1ps
module isr_ptr_calc
  import isr_pkg::*;
(
  // Pointer and addressing form
  input  wire isr_ptr_t   ptr,
  input  wire logic [1:0] mode,
  input  wire logic       rel,
  input  wire logic [5:0] offset,
  // Results
  output isr_ptr_t        eff_addr,
  output isr_ptr_t        next_ptr
);

  isr_ptr_t ptr_inc;
  isr_ptr_t ptr_dec;
  isr_ptr_t ptr_rel;

  // 16-bit sums wrap modulo the pointer range
  assign ptr_inc = ptr + 16'h0001;
  assign ptr_dec = ptr - 16'h0001;
  assign ptr_rel = ptr + {{10{offset[5]}}, offset};

  always_comb begin
    eff_addr = ptr;
    next_ptr = ptr;
    if (rel) begin
      eff_addr = ptr_rel;
      next_ptr = ptr;
    end else begin
      case (isr_mode_e'(mode))
        mode_pre_inc: begin
          eff_addr = ptr_inc;
          next_ptr = ptr_inc;
        end
        mode_pre_dec: begin
          eff_addr = ptr_dec;
          next_ptr = ptr_dec;
        end
        mode_post_inc: begin
          eff_addr = ptr;
          next_ptr = ptr_inc;
        end
        mode_post_dec: begin
          eff_addr = ptr;
          next_ptr = ptr_dec;
        end
        default: begin
          eff_addr = ptr;
          next_ptr = ptr;
        end
      endcase
    end
  end

endmodule : isr_ptr_calc

// ===== src/isr_reset_pulse.sv
// Stretches a one-cycle reset trigger into a fixed-length request
`timescale 1ns/1ps
module isr_reset_pulse #(
  parameter logic [3:0] PULSE_CYC = 4'h8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Trigger and request
  input  wire logic trigger,
  output logic      req
);

  logic [3:0] count;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 4'h0;
    end else if (trigger) begin
      count <= PULSE_CYC;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req <= 1'b0;
    end else begin
      req <= trigger || (count > 4'h1);
    end
  end

endmodule : isr_reset_pulse

// ===== src/isr_core.sv
// Indirect store, no-operation and software reset execution unit
//
// Contract
// - Store writes the working register to memory at the selected pointer.
// - Mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Offset form addresses pointer plus signed -32..31; pointer kept.
// - Pointer ends plus one, minus one, or unchanged for offset form.
// - Alias registers hold no storage; they only redirect an access.
// - Access to an alias goes to the address in its pointer.
// - Pointers are 16 bits and wrap modulo 10000h.
// - Pointer updates by the store leave every status flag alone.
// - Software reset triggers a full device reset; no operands; status flags return to their reset value.
// - Software reset clears the reset-instruction flag.
`timescale 1ns/1ps
`include "isr_regs.svh"
module isr_core
  import isr_pkg::*;
#(
  parameter logic [3:0] RST_PULSE_CYC = `ISR_RST_PULSE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Instruction issue
  input  wire logic        instr_valid,
  input  wire isr_op_e     instr_op,
  input  wire logic        instr_sel,
  input  wire logic [1:0]  instr_mode,
  input  wire logic        instr_rel,
  input  wire logic [5:0]  instr_offset,
  input  wire logic [7:0]  w_value,
  // Core data access that may hit an alias
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [15:0] acc_addr,
  input  wire logic [7:0]  acc_wdata,
  // Data memory port
  output logic             mem_we,
  output logic             mem_re,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  // Device reset request
  output logic             dev_reset_req,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  isr_ptr_t   ptr [2];
  isr_ptr_t   eff [2];
  isr_ptr_t   nxt [2];
  logic       reset_instruction_flag;
  logic [1:0] status_flags;
  isr_ptr_t   last_addr;

  logic do_store;
  logic do_reset;
  logic hit_alias0;
  logic hit_alias1;
  logic alias_hit;
  logic alias_sel;

  assign do_store   = instr_valid && (instr_op == op_store_w_indirect);
  assign do_reset   = instr_valid && (instr_op == op_sw_reset);
  // Instructions win over a same-cycle data access
  assign hit_alias0 = acc_valid && !instr_valid
                      && (acc_addr == `ISR_ALIAS0_ADDR);
  assign hit_alias1 = acc_valid && !instr_valid
                      && (acc_addr == `ISR_ALIAS1_ADDR);
  assign alias_hit  = hit_alias0 || hit_alias1;
  assign alias_sel  = hit_alias1;

  // ----------------------------------------------------------------
  // Address arithmetic, one unit per pointer
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < 2; i++) begin : g_calc
      isr_ptr_calc u_calc (
        .ptr      (ptr[i]),
        .mode     (instr_mode),
        .rel      (instr_rel),
        .offset   (instr_offset),
        .eff_addr (eff[i]),
        .next_ptr (nxt[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  // A store's own update beats a software write in the same cycle
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ptr
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ptr[i] <= `ISR_PTR_RST;
        end else if (do_reset) begin
          ptr[i] <= `ISR_PTR_RST;
        end else if (do_store && (instr_sel == 1'(i))) begin
          ptr[i] <= nxt[i];
        end else if (reg_wr && (reg_addr == 4'(i))) begin
          ptr[i] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Data memory port
  // ----------------------------------------------------------------
  // Aliases have no flop of their own: only the address is rewritten
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
    end else if (do_store) begin
      mem_we    <= 1'b1;
      mem_re    <= 1'b0;
      mem_addr  <= eff[instr_sel];
      mem_wdata <= w_value;
    end else if (acc_valid && !instr_valid) begin
      mem_we    <= acc_write;
      mem_re    <= !acc_write;
      mem_addr  <= alias_hit ? ptr[alias_sel] : acc_addr;
      mem_wdata <= acc_wdata;
    end else begin
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_addr <= 16'h0000;
    end else if (do_store) begin
      last_addr <= eff[instr_sel];
    end
  end

  // ----------------------------------------------------------------
  // Status flags and power control
  // ----------------------------------------------------------------
  // Flags change only by software writes and software reset; stores never touch them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_flags <= `ISR_STATUS_RST;
    end else if (do_reset) begin
      status_flags <= `ISR_STATUS_RST;
    end else if (reg_wr && (reg_addr == `ISR_REG_STATUS)) begin
      status_flags <= reg_wdata[1:0];
    end
  end

  // The hardware clear wins over a software set in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_instruction_flag <= `ISR_RI_RST;
    end else if (do_reset) begin
      reset_instruction_flag <= 1'b0;
    end else if (reg_wr && (reg_addr == `ISR_REG_POWER_CTRL)) begin
      reset_instruction_flag <= reg_wdata[`ISR_RI_BIT];
    end
  end

  isr_reset_pulse #(
    .PULSE_CYC (RST_PULSE_CYC)
  ) u_rst (
    .clk     (clk),
    .reset_n (reset_n),
    .trigger (do_reset),
    .req     (dev_reset_req)
  );

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ISR_REG_PTR0:       reg_rdata <= ptr[0];
        `ISR_REG_PTR1:       reg_rdata <= ptr[1];
        `ISR_REG_POWER_CTRL: reg_rdata <= {15'h0000,
                                           reset_instruction_flag};
        `ISR_REG_STATUS:     reg_rdata <= {14'h0000, status_flags};
        `ISR_REG_LAST_ADDR:  reg_rdata <= last_addr;
        default:             reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence store_on(logic s, logic [1:0] m, logic r);
    do_store && instr_sel == s && instr_mode == m && instr_rel == r;
  endsequence

  sequence reset_seen;
    do_reset;
  endsequence

  sequence req_held;
    dev_reset_req [*8];
  endsequence

  store_write_a: assert property (
    do_store |=> mem_we && mem_wdata == $past(w_value))
    else $error("store did not write the working register");

  pre_inc_a: assert property (
    store_on(1'b0, 2'b00, 1'b0) |=>
      mem_addr == $past(ptr[0]) + 16'h0001 && mem_addr == ptr[0])
    else $error("pre-increment address wrong");

  post_dec_a: assert property (
    store_on(1'b1, 2'b11, 1'b0) |=>
      mem_addr == $past(ptr[1]) && ptr[1] == mem_addr - 16'h0001)
    else $error("post-decrement address wrong");

  rel_offset_a: assert property (
    store_on(1'b0, instr_mode, 1'b1) |=>
      mem_addr == $past(ptr[0]) + {{10{$past(instr_offset[5])}},
                                   $past(instr_offset)}
      && $stable(ptr[0]))
    else $error("offset form address or pointer wrong");

  ptr_after_a: assert property (
    store_on(1'b1, 2'b10, 1'b0) |=> ptr[1] == $past(ptr[1]) + 16'h0001)
    else $error("pointer not advanced after store");

  ptr_wrap_a: assert property (
    store_on(1'b0, 2'b00, 1'b0) ##0 (ptr[0] == 16'hFFFF) |=>
      ptr[0] == 16'h0000 && mem_addr == 16'h0000)
    else $error("pointer did not wrap");

  flags_hold_a: assert property (
    do_store && !reg_wr |=> $stable(status_flags))
    else $error("store changed a status flag");

  alias_redir_a: assert property (
    hit_alias1 && !do_store |=> mem_addr == $past(ptr[1]))
    else $error("alias access not redirected");

  ri_clear_a: assert property (
    reset_seen |=> !reset_instruction_flag && dev_reset_req)
    else $error("reset flag not cleared");

  reset_len_a: assert property (
    reset_seen ##1 !do_reset [*8] |-> dev_reset_req ##1 !dev_reset_req)
    else $error("reset request length wrong");

  nop_quiet_a: assert property (
    instr_valid && instr_op == op_no_operation |=>
      !mem_we && $stable(ptr[0]) && $stable(ptr[1]))
    else $error("no-operation changed state");

  pre_dec_a: assert property (
    store_on(1'b0, 2'b01, 1'b0) |=>
      mem_addr == $past(ptr[0]) - 16'h0001 && ptr[0] == mem_addr)
    else $error("pre-decrement address wrong");

  post_inc_a: assert property (
    store_on(1'b1, 2'b10, 1'b0) |=>
      mem_addr == $past(ptr[1]) && ptr[1] == mem_addr + 16'h0001)
    else $error("post-increment address wrong");

  rel_ptr1_a: assert property (
    store_on(1'b1, instr_mode, 1'b1) |=>
      mem_addr == $past(ptr[1]) + {{10{$past(instr_offset[5])}},
                                   $past(instr_offset)}
      && $stable(ptr[1]))
    else $error("offset form on second pointer wrong");

  alias0_redir_a: assert property (
    hit_alias0 |=> mem_addr == $past(ptr[0]) && (mem_we || mem_re))
    else $error("first alias access not redirected");

  alias_write_a: assert property (
    hit_alias0 && acc_write && !reg_wr |=>
      mem_we && mem_wdata == $past(acc_wdata) && $stable(ptr[0]))
    else $error("alias write was stored locally");

  nop_mem_a: assert property (
    instr_valid && instr_op == op_no_operation && !reg_wr |=>
      !mem_re && $stable(status_flags)
      && $stable(reset_instruction_flag))
    else $error("no-operation touched memory or flags");

  flags_reset_a: assert property (
    reset_seen |=> ptr[0] == `ISR_PTR_RST && ptr[1] == `ISR_PTR_RST
      && status_flags == `ISR_STATUS_RST)
    else $error("software reset left state behind");

  req_held_a: assert property (
    reset_seen |=> req_held)
    else $error("reset request dropped early");

endmodule : isr_core

// ===== testbench/indirect_store_and_sw_reset_tb_top.sv
// Self-checking bench for the indirect store and software reset core
`timescale 1ns/1ps
`include "isr_regs.svh"
module indirect_store_and_sw_reset_tb_top
  import isr_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [3:0] PULSE = 4'h8;
  localparam int         LIMIT = 5000;
  logic        clk, reset_n, instr_valid, instr_sel, instr_rel;
  logic        acc_valid, acc_write, reg_wr, reg_rd;
  isr_op_e     instr_op;
  logic [1:0]  instr_mode;
  logic [5:0]  instr_offset;
  logic [7:0]  w_value, acc_wdata, mem_wdata;
  logic [15:0] acc_addr, reg_wdata, mem_addr, reg_rdata, rd, r0, r1, cnt;
  logic [3:0]  reg_addr;
  logic        mem_we, mem_re, dev_reset_req;
  int          bad_count, n_compared, cycles;
  int unsigned seed;

  isr_core #(.RST_PULSE_CYC(PULSE)) uut (
    .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_sel(instr_sel), .instr_mode(instr_mode),
    .instr_rel(instr_rel), .instr_offset(instr_offset),
    .w_value(w_value), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .dev_reset_req(dev_reset_req), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Bounded run: a hung handshake ends as a failure, not a stall
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Expectations and bus tasks
  // ------------------------------------------------------------
  function automatic logic [15:0] exp_addr(logic [15:0] p, logic [1:0] m,
                                           logic rel, logic [5:0] off);
    if (rel) return p + {{10{off[5]}}, off};
    case (m)
      2'h0:    return p + 16'h0001;
      2'h1:    return p - 16'h0001;
      default: return p;
    endcase
  endfunction : exp_addr

  function automatic logic [15:0] exp_ptr(logic [15:0] p, logic [1:0] m,
                                          logic rel);
    if (rel) return p;
    return m[0] ? p - 16'h0001 : p + 16'h0001;
  endfunction : exp_ptr

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic issue(input isr_op_e op, input logic s, input logic [1:0] m,
                       input logic rel, input logic [5:0] off,
                       input logic [7:0] w);
    @(posedge clk);
    instr_valid  <= 1'b1;
    instr_op     <= op;
    instr_sel    <= s;
    instr_mode   <= m;
    instr_rel    <= rel;
    instr_offset <= off;
    w_value      <= w;
    @(posedge clk);
    instr_valid  <= 1'b0;
    #1;
  endtask : issue

  task automatic access(input logic wr, input logic [15:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_addr  <= a;
    acc_wdata <= d;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
  endtask : access

  task automatic store_check(input logic s, input logic [1:0] m,
                             input logic rel, input logic [5:0] off,
                             input logic [15:0] p, input logic [7:0] w);
    logic [3:0] pa;
    pa = s ? `ISR_REG_PTR1 : `ISR_REG_PTR0;
    reg_write(pa, p);
    issue(op_store_w_indirect, s, m, rel, off, w);
    check(mem_we, 16'h0001);
    check(mem_addr, exp_addr(p, m, rel, off));
    check(mem_wdata, {8'h00, w});
    @(posedge clk);
    #1;
    check(mem_we, 16'h0000);
    reg_read(pa, rd);
    check(rd, exp_ptr(p, m, rel));
    reg_read(`ISR_REG_LAST_ADDR, rd);
    check(rd, exp_addr(p, m, rel, off));
  endtask : store_check

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {reset_n, instr_valid, instr_sel, instr_rel, acc_valid} = '0;
    {acc_write, reg_wr, reg_rd, instr_mode, instr_offset} = '0;
    {w_value, acc_wdata, acc_addr, reg_wdata, reg_addr} = '0;
    instr_op = op_no_operation;
    {bad_count, n_compared, cycles} = '0;
    seed = $urandom(56292);
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    reg_read(`ISR_REG_PTR0, rd);
    check(rd, `ISR_PTR_RST);
    reg_read(`ISR_REG_POWER_CTRL, rd);
    check(rd, {15'h0000, `ISR_RI_RST});
    reg_read(4'hF, rd);
    check(rd, 16'h0000);
    // Every mode at the wrap boundary, first pointer for modes 00 and 01, second for 10 and 11
    for (int m = 0; m < 4; m++) begin
      store_check(m[1], m[1:0], 1'b0, 6'h00,
                  m[0] ? 16'h0000 : 16'hFFFF, 8'hA5);
    end
    store_check(1'b0, 2'h1, 1'b1, 6'h20, 16'h0010, 8'h3C);
    store_check(1'b1, 2'h0, 1'b1, 6'h1F, 16'hFFF0, 8'hC3);
    repeat (40) begin
      store_check(1'($urandom), 2'($urandom), 1'($urandom),
                  6'($urandom), 16'($urandom), 8'($urandom));
    end
    reg_write(`ISR_REG_STATUS, 16'h0003);
    store_check(1'b0, 2'h1, 1'b0, 6'h00, 16'h0001, 8'h00);
    reg_read(`ISR_REG_STATUS, rd);
    check(rd, 16'h0003);
    // No-operation touches nothing
    reg_read(`ISR_REG_PTR0, r0);
    issue(op_no_operation, 1'b0, 2'h0, 1'b0, 6'h00, 8'hFF);
    check({mem_we, mem_re}, 16'h0000);
    reg_read(`ISR_REG_PTR0, rd);
    check(rd, r0);
    reg_read(`ISR_REG_STATUS, rd);
    check(rd, 16'h0003);
    // Alias accesses redirect through the pointers
    r0 = 16'($urandom);
    r1 = 16'($urandom);
    reg_write(`ISR_REG_PTR0, r0);
    reg_write(`ISR_REG_PTR1, r1);
    access(1'b0, `ISR_ALIAS1_ADDR, 8'h00);
    check(mem_re, 16'h0001);
    check(mem_addr, r1);
    access(1'b1, `ISR_ALIAS0_ADDR, 8'h5A);
    check({mem_we, mem_wdata}, 16'h015A);
    check(mem_addr, r0);
    access(1'b0, 16'h0100, 8'h00);
    check(mem_addr, 16'h0100);
    reg_read(`ISR_REG_PTR0, rd);
    check(rd, r0);
    // Software reset: fixed request length, flag cleared, state reset
    issue(op_sw_reset, 1'b1, 2'h3, 1'b1, 6'h3F, 8'hFF);
    cnt = 16'h0000;
    while (dev_reset_req === 1'b1 && cnt < 16'h0014) begin
      cnt++;
      @(posedge clk);
      #1;
    end
    check(cnt, {12'h000, PULSE});
    reg_read(`ISR_REG_POWER_CTRL, rd);
    check(rd, 16'h0000);
    reg_read(`ISR_REG_PTR1, rd);
    check(rd, `ISR_PTR_RST);
    reg_read(`ISR_REG_STATUS, rd);
    check(rd, {14'h0000, `ISR_STATUS_RST});
    reg_write(`ISR_REG_POWER_CTRL, 16'h0001);
    reg_read(`ISR_REG_POWER_CTRL, rd);
    check(rd, 16'h0001);
    // Power-on reset restores the flag that software cleared
    reg_write(`ISR_REG_POWER_CTRL, 16'h0000);
    reg_read(`ISR_REG_POWER_CTRL, rd);
    check(rd, 16'h0000);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    reg_read(`ISR_REG_POWER_CTRL, rd);
    check(rd, {15'h0000, `ISR_RI_RST});
    conclude();
  end
endmodule : indirect_store_and_sw_reset_tb_top
